/* bench/hbls_host_mdl.sv */
// Host processor model on the multiplexed strobe bus
`timescale 1ns/10ps
module hbls_host_mdl (
    input  wire logic                ref_clk_i,
    output hbls_pkg::hbls_req_t      req_o,
    input  wire hbls_pkg::hbls_rsp_t rsp_i
);
    import hbls_pkg::*;
    initial req_o = '0;
    // Released address/data lines show the inverse of the last value; wr and word keep theirs
    task automatic access(input logic wr, input logic wd, input logic [7:0] a,
                          input logic [15:0] wdat, input int slow,
                          output logic [15:0] rdat, output logic ok);
        int n;
        @(posedge ref_clk_i);
        req_o <= '{1'b1, 1'b0, 1'b0, 1'b0, {8'h00, a}};
        @(posedge ref_clk_i);
        req_o.as <= 1'b0;
        repeat (slow) @(posedge ref_clk_i);
        req_o <= '{1'b0, 1'b1, wr, wd, wdat};
        n = 0;
        // Strobe held until the edge that sees ack; answer taken at that edge
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (!rsp_i.ack && n < 8);
        rdat = rsp_i.ad;
        ok   = rsp_i.ack;
        req_o <= '{1'b0, 1'b0, wr, wd, ~wdat};
    endtask : access
endmodule : hbls_host_mdl

/* bench/hbls_host_port_chk.sv */
// Checker of host port handshake, lane steering and channel selection
`timescale 1ns/10ps
`include "hbls_regs.svh"
module hbls_host_port_chk #(
    parameter int NCHAN = 4
) (
    input wire logic                ref_clk_i,
    input wire logic                rstn_i,
    input wire logic                ce_i,
    input wire logic                byte_order_strap_i,
    input wire hbls_pkg::hbls_req_t bus_req_i,
    input wire hbls_pkg::hbls_ctx_t ctx_i,
    input wire hbls_pkg::hbls_rsp_t bus_rsp_o,
    input wire logic [1:0]          active_chan_o,
    input wire logic                sync_mode_o
);
    import hbls_pkg::*;
    logic [1:0] ph_r;
    logic [7:0] a_r;
    // Own phase tracker, so a stuck design phase cannot hide itself
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ph_r <= 2'h0;
            a_r  <= 8'h00;
        end else if (ce_i) begin
            case (ph_r)
                2'h0: if (bus_req_i.as) begin
                    ph_r <= 2'h1;
                    a_r  <= bus_req_i.ad[7:0];
                end
                2'h1: if (bus_req_i.ds) ph_r <= 2'h2;
                default: ph_r <= 2'h0;
            endcase
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    chk_ack_timing: assert property (ce_i && ph_r == 2'h1 && bus_req_i.ds |=> bus_rsp_o.ack)
        else $error("ack missing after data strobe");
    chk_ack_pulse: assert property (bus_rsp_o.ack && ce_i |=> !bus_rsp_o.ack)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(bus_rsp_o.ack) |-> $past(ph_r == 2'h1 && bus_req_i.ds))
        else $error("ack without data strobe");
    chk_oe_read: assert property (bus_rsp_o.ack |-> bus_rsp_o.oe == !$past(bus_req_i.wr))
        else $error("output enable does not match read");
    chk_idle_quiet: assert property (!bus_rsp_o.oe |-> bus_rsp_o.ad == 16'h0000)
        else $error("read data outside read ack");
    chk_lane_low: assert property (bus_rsp_o.oe && !$past(bus_req_i.word)
        && (a_r[0] ^ byte_order_strap_i) |-> bus_rsp_o.ad[15:8] == 8'h00)
        else $error("byte read on wrong lane");
    chk_lane_high: assert property (bus_rsp_o.oe && !$past(bus_req_i.word)
        && !(a_r[0] ^ byte_order_strap_i) |-> bus_rsp_o.ad[7:0] == 8'h00)
        else $error("byte read on wrong lane");
    chk_ctx_chan: assert property (ctx_i.valid |-> active_chan_o == ctx_i.chan)
        else $error("context channel not applied");
    chk_chan_hold: assert property (!ctx_i.valid && $past(!ctx_i.valid)
        && !(bus_rsp_o.ack && !bus_rsp_o.oe) |-> $stable(active_chan_o))
        else $error("channel changed without write");
    chk_chan_write: assert property (bus_rsp_o.ack && !bus_rsp_o.oe && !ctx_i.valid
        && !$past(bus_req_i.word) && a_r == (byte_order_strap_i ? `HBLS_LO_CHSEL : `HBLS_HI_CHSEL)
        |-> active_chan_o == (byte_order_strap_i ? $past(bus_req_i.ad[1:0])
        : $past(bus_req_i.ad[9:8])))
        else $error("channel select write not applied");
endmodule : hbls_host_port_chk
bind hbls_host_port hbls_host_port_chk #(.NCHAN(NCHAN)) i_hbls_host_port_chk (.ref_clk_i,
    .rstn_i, .ce_i, .byte_order_strap_i, .bus_req_i, .ctx_i, .bus_rsp_o, .active_chan_o,
    .sync_mode_o);

/* bench/hbls_host_port_tb_top.sv */
// Self-checking testbench of the host port
`timescale 1ns/10ps
`include "hbls_regs.svh"
module hbls_host_port_tb_top;
    import hbls_pkg::*;
    logic       ref_clk_i = 1'b0;
    logic       rstn_i    = 1'b0;
    logic       strap     = 1'b1;
    hbls_req_t  req;
    hbls_ctx_t  ctx       = '0;
    hbls_rsp_t  rsp;
    logic [1:0] ach;
    logic       syn;
    logic [7:0] sh_fw, sh_cs;
    logic [7:0] sh_md [4];
    logic [7:0] sh_al [2][4][4];
    logic [15:0] rnd;
    int         fails = 0, n_checks = 0, seed = 61;
    always #4 ref_clk_i = ~ref_clk_i;
    hbls_host_port i_hbls_host_port (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .byte_order_strap_i(strap), .bus_req_i(req), .ctx_i(ctx), .bus_rsp_o(rsp),
        .active_chan_o(ach), .sync_mode_o(syn));
    hbls_host_mdl i_hbls_host_mdl (.ref_clk_i(ref_clk_i), .req_o(req), .rsp_i(rsp));
    function automatic logic [7:0] am(input logic [7:0] lo, input logic [7:0] hi);
        return strap ? lo : hi;
    endfunction : am
    function automatic int dec(input logic [7:0] a);
        if (a == am(`HBLS_LO_FWREV, `HBLS_HI_FWREV)) return 1;
        if (a == am(`HBLS_LO_CHSEL, `HBLS_HI_CHSEL)) return 2;
        if (a == am(`HBLS_LO_MODE, `HBLS_HI_MODE)) return 3;
        if (a >= 8'h1C && a <= 8'h1F) return strap ? 4 + a - 8'h1C : 4 + 8'h1F - a;
        return 0;
    endfunction : dec
    function automatic logic [1:0] chan();
        return ctx.valid ? ctx.chan : sh_cs[1:0];
    endfunction : chan
    function automatic logic [7:0] ref_rd(input logic [7:0] a);
        int d;
        d = dec(a);
        if (d == 1) return sh_fw;
        if (d == 2) return sh_cs;
        if (d == 3) return sh_md[chan()];
        if (d >= 4) return sh_al[sh_md[chan()][7]][chan()][d-4];
        return 8'h00;
    endfunction : ref_rd
    task automatic ref_wr(input logic [7:0] a, input logic [7:0] v);
        int d;
        d = dec(a);
        if (d == 1) sh_fw = v;
        if (d == 2) sh_cs = v;
        if (d == 3) sh_md[chan()] = v;
        if (d >= 4) sh_al[sh_md[chan()][7]][chan()][d-4] = v;
    endtask : ref_wr
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic op(input logic wr, input logic wd, input logic [7:0] a, input logic [15:0] d);
        logic [15:0] e, r;
        logic [7:0]  x;
        logic        ok;
        e = 16'h0000;
        for (int k = 0; k <= int'(wd); k++) begin
            x = wd ? {a[7:1], k[0]} : a;
            if (x[0] ^ strap) begin
                if (wr) ref_wr(x, d[7:0]);
                else e[7:0] = ref_rd(x);
            end else begin
                if (wr) ref_wr(x, d[15:8]);
                else e[15:8] = ref_rd(x);
            end
        end
        i_hbls_host_mdl.access(wr, wd, a, d, $unsigned($random(seed)) % 3, r, ok);
        cmp({15'h0000, ok}, 16'h0001);
        cmp(r, e);
    endtask : op
    task automatic chk_chan();
        @(negedge ref_clk_i);
        cmp({14'h0000, ach}, {14'h0000, chan()});
        cmp({15'h0000, syn}, {15'h0000, sh_md[chan()][7]});
    endtask : chk_chan
    task automatic complete_run();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fails++;
        complete_run();
    end
    initial begin
        sh_fw = 8'h5A;
        sh_cs = 8'h00;
        sh_md = '{default: 8'h00};
        sh_al = '{default: 8'h00};
        repeat (6) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        for (int s = 1; s >= 0; s--) begin
            @(posedge ref_clk_i);
            strap <= s[0];
            @(posedge ref_clk_i);
            op(1'b0, 1'b0, am(8'h82, 8'h81), 16'h0000);
            rnd = $random(seed);
            op(1'b1, 1'b0, am(8'h82, 8'h81), rnd);
            op(1'b0, 1'b1, 8'h80, 16'h0000);
            op(1'b0, 1'b1, 8'h82, 16'h0000);
            op(1'b1, 1'b0, 8'h83, rnd);
            op(1'b0, 1'b0, 8'h83, 16'h0000);
            for (int c = 0; c < 4; c++) begin
                op(1'b1, 1'b0, am(`HBLS_LO_CHSEL, `HBLS_HI_CHSEL), {2{6'h00, c[1:0]}});
                rnd = $random(seed);
                op(1'b1, 1'b0, am(`HBLS_LO_MODE, `HBLS_HI_MODE), rnd);
                op(1'b1, 1'b1, 8'h1C, $random(seed));
                op(1'b1, 1'b1, 8'h1E, $random(seed));
                op(1'b1, 1'b0, am(`HBLS_LO_MODE, `HBLS_HI_MODE), ~rnd);
                op(1'b1, 1'b1, 8'h1C, $random(seed));
            end
            for (int c = 0; c < 4; c++) begin
                op(1'b1, 1'b0, am(`HBLS_LO_CHSEL, `HBLS_HI_CHSEL), {2{6'h00, c[1:0]}});
                chk_chan();
                op(1'b0, 1'b0, am(`HBLS_LO_MODE, `HBLS_HI_MODE), 16'h0000);
                op(1'b0, 1'b1, 8'h1C, 16'h0000);
                op(1'b0, 1'b0, am(8'h82, 8'h81), 16'h0000);
                @(posedge ref_clk_i);
                ctx <= '{1'b1, 2'(3 - c)};
                chk_chan();
                op(1'b0, 1'b1, 8'h1E, 16'h0000);
                @(posedge ref_clk_i);
                ctx <= '0;
                chk_chan();
                op(1'b0, 1'b0, am(`HBLS_LO_MODE, `HBLS_HI_MODE), 16'h0000);
            end
        end
        @(posedge ref_clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        sh_fw = 8'h5A;
        sh_cs = 8'h00;
        sh_md = '{default: 8'h00};
        sh_al = '{default: 8'h00};
        chk_chan();
        op(1'b0, 1'b1, 8'h80, 16'h0000);
        complete_run();
    end
endmodule : hbls_host_port_tb_top

/* verilog/hbls_host_port.sv */
// Host bus lane steering, register map decode and channel selection
`timescale 1ns/10ps
`include "hbls_regs.svh"

// Overview of operation
// - Strap high puts low-lane byte first in byte strings; low puts high lane first.
// - Strap high: A0 low uses low lane; strap low inverts lane choice.
// - Strap changes lanes, byte order and address map, never handshake timing.
// - Strap selects one of two address maps; each register has both offsets.
// - One set of global registers, reachable whatever channel is selected.
// - NCHAN copies (one to four) of per-channel registers; only the active channel answers.
// - Host writes channel select; it stays until the host writes again.
// - Interrupt or DMA context supplies the channel number by itself.
// - Some per-channel offsets mean different registers in async and sync mode.
// - Byte-wide global firmware revision at 82 or 81 depending on map.
module hbls_host_port #(
    parameter int          NCHAN      = 4,
    parameter logic [7:0]  FW_REV_RST = 8'h5A // Arbitrary revision value
) (
    input  wire logic               ref_clk_i,
    input  wire logic               rstn_i,
    input  wire logic               ce_i,
    input  wire logic               byte_order_strap_i,
    input  wire hbls_pkg::hbls_req_t bus_req_i,
    input  wire hbls_pkg::hbls_ctx_t ctx_i,
    output hbls_pkg::hbls_rsp_t     bus_rsp_o,
    output logic [1:0]              active_chan_o,
    output logic                    sync_mode_o
);
    import hbls_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    generate
        if (NCHAN < 1 || NCHAN > 4) begin : g_bad_nchan
            $error("NCHAN must lie between 1 and 4");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic hbls_reg_t dec_reg(input logic       strap,
                                          input logic [7:0] addr);
        hbls_reg_t   rg;
        logic [7:0]  off;
        rg = HBLS_RG_NONE;
        if (strap) begin
            if (addr == `HBLS_LO_FWREV) begin
                rg = HBLS_RG_FWREV;
            end else if (addr == `HBLS_LO_CHSEL) begin
                rg = HBLS_RG_CHSEL;
            end else if (addr == `HBLS_LO_MODE) begin
                rg = HBLS_RG_MODE;
            end else begin
                off = addr - `HBLS_LO_ALIAS0;
                if (off < {5'h00, `HBLS_ALIAS_NUM}) begin
                    rg = HBLS_RG_ALIAS;
                end
            end
        end else begin
            if (addr == `HBLS_HI_FWREV) begin
                rg = HBLS_RG_FWREV;
            end else if (addr == `HBLS_HI_CHSEL) begin
                rg = HBLS_RG_CHSEL;
            end else if (addr == `HBLS_HI_MODE) begin
                rg = HBLS_RG_MODE;
            end else begin
                off = `HBLS_HI_ALIAS0 - addr;
                if (off < {5'h00, `HBLS_ALIAS_NUM}) begin
                    rg = HBLS_RG_ALIAS;
                end
            end
        end
        return rg;
    endfunction : dec_reg

    function automatic logic [1:0] alias_idx(input logic       strap,
                                             input logic [7:0] addr);
        logic [7:0] off;
        if (strap) begin
            off = addr - `HBLS_LO_ALIAS0;
        end else begin
            off = `HBLS_HI_ALIAS0 - addr;
        end
        return off[1:0];
    endfunction : alias_idx

    // Lane of a byte: low lane when A0 differs from the strap level
    function automatic logic low_lane(input logic strap,
                                      input logic a0);
        return a0 ^ strap;
    endfunction : low_lane

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    hbls_phase_t  phase_r,   phase_nxt;
    logic [7:0]   addr_r,    addr_nxt;
    logic [7:0]   fwrev_r,   fwrev_nxt;
    logic [7:0]   chsel_r,   chsel_nxt;
    logic [7:0]   mode_r     [NCHAN];
    logic [7:0]   mode_nxt   [NCHAN];
    logic [7:0]   schar_r    [NCHAN][4];
    logic [7:0]   schar_nxt  [NCHAN][4];
    logic [7:0]   faddr_r    [NCHAN][4];
    logic [7:0]   faddr_nxt  [NCHAN][4];
    hbls_rsp_t    rsp_r,     rsp_nxt;
    logic [1:0]   chan;
    logic         chan_ok;
    logic         is_sync;

    // ----------------------------------------------------------------
    // Active channel
    // ----------------------------------------------------------------
    // Context channel wins only while it is valid, then the host choice returns
    assign chan    = ctx_i.valid ? ctx_i.chan
                                 : chsel_r[`HBLS_CHAN_MSB:`HBLS_CHAN_LSB];
    assign chan_ok = ({30'h0, chan} < NCHAN);
    assign is_sync = chan_ok & mode_r[chan][`HBLS_SYNC_BIT];

    assign active_chan_o = chan;
    assign sync_mode_o   = is_sync;
    assign bus_rsp_o     = rsp_r;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0]  a;
        logic [7:0]  rb;
        logic [7:0]  wb;
        logic        lo;
        hbls_reg_t   rg;
        logic [1:0]  ix;
        a         = 8'h00;
        rb        = `HBLS_UNMAPPED;
        wb        = 8'h00;
        lo        = 1'b0;
        rg        = HBLS_RG_NONE;
        ix        = 2'h0;
        phase_nxt = phase_r;
        addr_nxt  = addr_r;
        fwrev_nxt = fwrev_r;
        chsel_nxt = chsel_r;
        mode_nxt  = mode_r;
        schar_nxt = schar_r;
        faddr_nxt = faddr_r;
        rsp_nxt   = '0;
        // Handshake path never looks at the strap
        case (phase_r)
            HBLS_PH_IDLE: begin
                if (bus_req_i.as) begin
                    addr_nxt  = bus_req_i.ad[7:0];
                    phase_nxt = HBLS_PH_ADDR;
                end
            end
            HBLS_PH_ADDR: begin
                if (bus_req_i.ds) begin
                    phase_nxt   = HBLS_PH_ACK;
                    rsp_nxt.ack = 1'b1;
                    rsp_nxt.oe  = ~bus_req_i.wr;
                    for (int k = 0; k < 2; k++) begin
                        if (k == 0 || bus_req_i.word) begin
                            // Word strings start at the even byte
                            if (bus_req_i.word) begin
                                a = {addr_r[7:1], k[0]};
                            end else begin
                                a = addr_r;
                            end
                            lo = low_lane(byte_order_strap_i, a[0]);
                            rg = dec_reg(byte_order_strap_i, a);
                            ix = alias_idx(byte_order_strap_i, a);
                            wb = lo ? bus_req_i.ad[7:0] : bus_req_i.ad[15:8];
                            rb = `HBLS_UNMAPPED;
                            case (rg)
                                HBLS_RG_FWREV: begin
                                    rb = fwrev_r;
                                    if (bus_req_i.wr) begin
                                        fwrev_nxt = wb;
                                    end
                                end
                                HBLS_RG_CHSEL: begin
                                    rb = chsel_r;
                                    if (bus_req_i.wr) begin
                                        chsel_nxt = wb;
                                    end
                                end
                                HBLS_RG_MODE: begin
                                    if (chan_ok) begin
                                        rb = mode_r[chan];
                                        if (bus_req_i.wr) begin
                                            mode_nxt[chan] = wb;
                                        end
                                    end
                                end
                                HBLS_RG_ALIAS: begin
                                    if (chan_ok && is_sync) begin
                                        rb = faddr_r[chan][ix];
                                        if (bus_req_i.wr) begin
                                            faddr_nxt[chan][ix] = wb;
                                        end
                                    end else if (chan_ok) begin
                                        rb = schar_r[chan][ix];
                                        if (bus_req_i.wr) begin
                                            schar_nxt[chan][ix] = wb;
                                        end
                                    end
                                end
                                default: begin
                                    rb = `HBLS_UNMAPPED;
                                end
                            endcase
                            if (!bus_req_i.wr) begin
                                if (lo) begin
                                    rsp_nxt.ad[7:0] = rb;
                                end else begin
                                    rsp_nxt.ad[15:8] = rb;
                                end
                            end
                        end
                    end
                end
            end
            HBLS_PH_ACK: begin
                phase_nxt = HBLS_PH_IDLE;
            end
            default: begin
                phase_nxt = HBLS_PH_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Clock enable low holds every flop, the answer included
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_r <= HBLS_PH_IDLE;
            addr_r  <= 8'h00;
            fwrev_r <= FW_REV_RST;
            chsel_r <= `HBLS_CHSEL_RST;
            rsp_r   <= '0;
            for (int c = 0; c < NCHAN; c++) begin
                mode_r[c] <= `HBLS_MODE_RST;
                for (int j = 0; j < 4; j++) begin
                    schar_r[c][j] <= `HBLS_ALIAS_RST;
                    faddr_r[c][j] <= `HBLS_ALIAS_RST;
                end
            end
        end else if (ce_i) begin
            phase_r <= phase_nxt;
            addr_r  <= addr_nxt;
            fwrev_r <= fwrev_nxt;
            chsel_r <= chsel_nxt;
            rsp_r   <= rsp_nxt;
            mode_r  <= mode_nxt;
            schar_r <= schar_nxt;
            faddr_r <= faddr_nxt;
        end
    end

endmodule : hbls_host_port

/* verilog/hbls_pkg.sv */
// Types shared by the host port logic
package hbls_pkg;

    // ----------------------------------------------------------------
    // Bus carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        as;
        logic        ds;
        logic        wr;
        logic        word;
        logic [15:0] ad;
    } hbls_req_t;

    typedef struct packed {
        logic        ack;
        logic        oe;
        logic [15:0] ad;
    } hbls_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] chan;
    } hbls_ctx_t;

    // ----------------------------------------------------------------
    // Decoded targets and bus phases
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        HBLS_RG_NONE,
        HBLS_RG_FWREV,
        HBLS_RG_CHSEL,
        HBLS_RG_MODE,
        HBLS_RG_ALIAS
    } hbls_reg_t;

    typedef enum logic [1:0] {
        HBLS_PH_IDLE,
        HBLS_PH_ADDR,
        HBLS_PH_ACK
    } hbls_phase_t;

endpackage : hbls_pkg

/* verilog/hbls_regs.svh */
// Register offsets, field positions and reset values of the host port
`ifndef HBLS_REGS_SVH
`define HBLS_REGS_SVH

// ----------------------------------------------------------------
// Offsets, low-lane-first map
// ----------------------------------------------------------------
`define HBLS_LO_FWREV   8'h82
`define HBLS_LO_CHSEL   8'hEC
`define HBLS_LO_MODE    8'h18
`define HBLS_LO_ALIAS0  8'h1C

// ----------------------------------------------------------------
// Offsets, high-lane-first map
// ----------------------------------------------------------------
`define HBLS_HI_FWREV   8'h81
`define HBLS_HI_CHSEL   8'hEE
`define HBLS_HI_MODE    8'h1B
`define HBLS_HI_ALIAS0  8'h1F

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define HBLS_ALIAS_NUM  3'h4
`define HBLS_SYNC_BIT   7
`define HBLS_CHAN_LSB   0
`define HBLS_CHAN_MSB   1
`define HBLS_CHSEL_RST  8'h00
`define HBLS_MODE_RST   8'h00
`define HBLS_ALIAS_RST  8'h00
`define HBLS_UNMAPPED   8'h00

`endif
